// file: logic/rfm_operand_unit.sv
`timescale 1ns/10ps
`default_nettype none
module rfm_operand_unit (
	input wire logic [rfm_pkg::LONG_W-1:0] raw,
	input wire rfm_pkg::rfm_dtype_t dtype,
	input wire logic is_signed,
	output logic [rfm_pkg::LONG_W-1:0] ext,
	output rfm_pkg::rfm_fclass_t fclass
);
	import rfm_pkg::*;
	wire logic [SP_EXP_W-1:0] sp_exp;
	wire logic [SP_FRAC_W-1:0] sp_frac;
	wire logic fill_b;
	wire logic fill_h;
	wire logic fill_w;
	assign sp_exp = raw[SP_EXP_LSB +: SP_EXP_W];
	assign sp_frac = raw[SP_FRAC_W-1:0];
	// sign fill per width, zero fill when unsigned
	assign fill_b = is_signed & raw[7];
	assign fill_h = is_signed & raw[15];
	assign fill_w = is_signed & raw[31];
	always_comb begin
		case (dtype)
			DT_BYTE: ext = {{56{fill_b}}, raw[7:0]};
			DT_HALF: ext = {{48{fill_h}}, raw[15:0]};
			DT_WORD: ext = {{32{fill_w}}, raw[31:0]};
			DT_SINGLE: ext = {32'h00000000, raw[31:0]};
			default: ext = raw; // longword and double pass whole
		endcase
	end
	always_comb begin
		if (sp_exp == SP_EXP_MAX) begin
			if (sp_frac == '0)
				fclass = FC_INF;
			else if (sp_frac[SP_FRAC_W-1])
				fclass = FC_QNAN;
			else
				fclass = FC_SNAN;
		end else if (sp_exp == '0) begin
			fclass = (sp_frac == '0) ? FC_ZERO : FC_DENORM;
		end else begin
			fclass = FC_NORMAL;
		end
	end
endmodule : rfm_operand_unit
`default_nettype wire

// file: logic/rfm_register_file.sv
`timescale 1ns/10ps
`default_nettype none
module rfm_register_file (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic sup_mode,
	input wire logic ip_we,
	input wire logic [rfm_pkg::WORD_W-1:0] ip_wdata,
	output logic [rfm_pkg::WORD_W-1:0] ip_q,
	input wire logic [rfm_pkg::GPR_IDX_W-1:0] gpr_raddr,
	output logic [rfm_pkg::WORD_W-1:0] gpr_rdata,
	output logic gpr_rviol,
	input wire logic gpr_we,
	input wire logic [rfm_pkg::GPR_IDX_W-1:0] gpr_waddr,
	input wire logic [rfm_pkg::WORD_W-1:0] gpr_wdata,
	output logic gpr_wviol,
	input wire logic [rfm_pkg::FPR_IDX_W-1:0] fpr_raddr,
	output logic [rfm_pkg::LONG_W-1:0] fpr_rdata,
	input wire logic fpr_we,
	input wire logic [rfm_pkg::FPR_IDX_W-1:0] fpr_waddr,
	input wire logic [rfm_pkg::LONG_W-1:0] fpr_wdata,
	input wire logic pstat_we,
	input wire logic [rfm_pkg::WORD_W-1:0] pstat_wdata,
	output logic [rfm_pkg::WORD_W-1:0] program_status_word,
	input wire logic sstat_we,
	input wire logic [rfm_pkg::WORD_W-1:0] sstat_wdata,
	output logic [rfm_pkg::WORD_W-1:0] system_status_word,
	output logic sstat_viol,
	input wire rfm_pkg::rfm_sys_sel_t ctu_sel,
	input wire logic ctu_we,
	input wire logic [rfm_pkg::WORD_W-1:0] ctu_wdata,
	output logic [rfm_pkg::WORD_W-1:0] ctu_rdata,
	output logic ctu_viol,
	output logic [rfm_pkg::WORD_W-1:0] supervisor_directory_base,
	output logic [rfm_pkg::WORD_W-1:0] user_directory_base,
	output logic [rfm_pkg::WORD_W-1:0] ctu_control,
	output logic [rfm_pkg::WORD_W-1:0] ctu_reset_reg,
	input wire logic fault_ev,
	input wire logic [rfm_pkg::WORD_W-1:0] fault_vaddr,
	output logic [rfm_pkg::WORD_W-1:0] fault_address,
	input wire logic [rfm_pkg::PARCEL_W-1:0] parcel0,
	output logic [2:0] insn_len,
	output logic insn_macro,
	input wire rfm_pkg::rfm_src_t op_src,
	input wire logic [rfm_pkg::WORD_W-1:0] op_mem,
	input wire logic [rfm_pkg::WORD_W-1:0] op_imm,
	input wire rfm_pkg::rfm_dtype_t op_dtype,
	input wire logic op_signed,
	output logic [rfm_pkg::LONG_W-1:0] op_value,
	output rfm_pkg::rfm_fclass_t op_fclass
);
	import rfm_pkg::*;

	////////////////////////////////////////////////////////////////////
	// storage
	logic [WORD_W-1:0] gpr_mem [GPR_NUM];
	logic [LONG_W-1:0] fpr_mem [FPR_NUM];
	logic [WORD_W-1:0] ip_d;
	logic [WORD_W-1:0] pstat_d;
	logic [WORD_W-1:0] sstat_d;
	logic [WORD_W-1:0] sdb_d;
	logic [WORD_W-1:0] udb_d;
	logic [WORD_W-1:0] ctl_d;
	logic [WORD_W-1:0] rst_d;
	logic [WORD_W-1:0] flt_d;

	////////////////////////////////////////////////////////////////////
	// mode-aware register number mapping
	// user numbers fold onto the low bank so user code cannot reach supervisor storage
	function automatic logic [GPR_IDX_W-1:0] map_gpr(input logic sup,
			input logic [GPR_IDX_W-1:0] n);
		map_gpr = sup ? n : {1'b0, n[BANK_IDX_W-1:0]};
	endfunction : map_gpr

	function automatic logic user_blocked(input logic sup,
			input logic [GPR_IDX_W-1:0] n);
		user_blocked = !sup && ((n & SUP_BANK_BIT) != '0);
	endfunction : user_blocked

	wire logic [GPR_IDX_W-1:0] gpr_ridx;
	wire logic [GPR_IDX_W-1:0] gpr_widx;
	wire logic gpr_wok;
	wire logic sys_ok;
	assign gpr_ridx = map_gpr(sup_mode, gpr_raddr);
	assign gpr_widx = map_gpr(sup_mode, gpr_waddr);
	assign gpr_wok = gpr_we && !user_blocked(sup_mode, gpr_waddr);
	assign sys_ok = sup_mode;

	////////////////////////////////////////////////////////////////////
	// general and float banks, no reset on array contents
	always_ff @(posedge clk_sys) begin
		if (gpr_wok)
			gpr_mem[gpr_widx] <= gpr_wdata;
	end

	always_ff @(posedge clk_sys) begin
		if (fpr_we)
			fpr_mem[fpr_waddr] <= fpr_wdata; // float bank open in both modes
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			gpr_rdata <= WORD_RESET;
			gpr_rviol <= 1'b0;
			gpr_wviol <= 1'b0;
			fpr_rdata <= LONG_RESET;
		end else begin
			gpr_rdata <= user_blocked(sup_mode, gpr_raddr) ? WORD_RESET : gpr_mem[gpr_ridx];
			gpr_rviol <= user_blocked(sup_mode, gpr_raddr);
			gpr_wviol <= gpr_we && user_blocked(sup_mode, gpr_waddr);
			fpr_rdata <= fpr_mem[fpr_raddr];
		end
	end

	////////////////////////////////////////////////////////////////////
	// instruction pointer and status words
	assign ip_d = ip_we ? ip_wdata : ip_q;
	assign pstat_d = pstat_we ? pstat_wdata : program_status_word;
	assign sstat_d = (sstat_we && sys_ok) ? sstat_wdata : system_status_word;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ip_q <= IP_RESET;
			program_status_word <= WORD_RESET;
			system_status_word <= WORD_RESET;
			sstat_viol <= 1'b0;
		end else begin
			ip_q <= ip_d;
			program_status_word <= pstat_d;
			system_status_word <= sstat_d;
			sstat_viol <= sstat_we && !sys_ok;
		end
	end

	////////////////////////////////////////////////////////////////////
	// cache/translation unit registers
	wire logic ctu_wok;
	wire logic [WORD_W-1:0] ctu_mux;
	assign ctu_wok = ctu_we && sys_ok;
	assign sdb_d = (ctu_wok && ctu_sel == SYS_SUP_BASE) ? ctu_wdata
		: supervisor_directory_base;
	assign udb_d = (ctu_wok && ctu_sel == SYS_USER_BASE) ? ctu_wdata
		: user_directory_base;
	assign ctl_d = (ctu_wok && ctu_sel == SYS_CONTROL) ? ctu_wdata : ctu_control;
	assign rst_d = (ctu_wok && ctu_sel == SYS_RESET) ? ctu_wdata : ctu_reset_reg;
	// a hardware fault beats a software write in the same cycle
	assign flt_d = fault_ev ? fault_vaddr
		: (ctu_wok && ctu_sel == SYS_FAULT) ? ctu_wdata : fault_address;
	assign ctu_mux = (ctu_sel == SYS_SUP_BASE) ? supervisor_directory_base
		: (ctu_sel == SYS_USER_BASE) ? user_directory_base
		: (ctu_sel == SYS_FAULT) ? fault_address
		: (ctu_sel == SYS_CONTROL) ? ctu_control
		: (ctu_sel == SYS_RESET) ? ctu_reset_reg : WORD_RESET;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			supervisor_directory_base <= WORD_RESET;
			user_directory_base <= WORD_RESET;
			ctu_control <= WORD_RESET;
			ctu_reset_reg <= WORD_RESET;
			fault_address <= WORD_RESET;
			ctu_rdata <= WORD_RESET;
			ctu_viol <= 1'b0;
		end else begin
			supervisor_directory_base <= sdb_d;
			user_directory_base <= udb_d;
			ctu_control <= ctl_d;
			ctu_reset_reg <= rst_d;
			fault_address <= flt_d;
			ctu_rdata <= sys_ok ? ctu_mux : WORD_RESET;
			ctu_viol <= ctu_we && !sys_ok;
		end
	end

	////////////////////////////////////////////////////////////////////
	// parcel length and macro classification
	// length taken from the format field in the low nibble of the first parcel;
	// the exact formats are not modelled, only the parcel count
	wire logic [3:0] fmt;
	wire logic [7:0] opc;
	wire logic [2:0] len_d;
	assign fmt = parcel0[3:0];
	assign opc = parcel0[PARCEL_W-1 -: 8];
	assign len_d = (fmt == FMT_IMM16) ? LEN_TWO
		: (fmt == FMT_IMM32 || fmt == FMT_ABS32) ? LEN_THREE
		: (fmt == FMT_DISP_LONG) ? LEN_FOUR : LEN_ONE;

	function automatic logic is_macro(input logic [7:0] code);
		is_macro = (code >= MACRO_OPCODE_BASE)
			&& (32'(code) < 32'(MACRO_OPCODE_BASE) + MACRO_OPS);
	endfunction : is_macro

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			insn_len <= LEN_ONE;
			insn_macro <= 1'b0;
		end else begin
			insn_len <= len_d;
			insn_macro <= is_macro(opc);
		end
	end

	////////////////////////////////////////////////////////////////////
	// operand source selection and typing
	wire logic [WORD_W-1:0] src_word;
	wire logic [LONG_W-1:0] src_raw;
	wire logic [LONG_W-1:0] ext_w;
	rfm_fclass_t fclass_w;
	assign src_word = (op_src == SRC_MEM) ? op_mem
		: (op_src == SRC_IMM) ? op_imm : gpr_rdata;
	// double operands come from the float read port, the rest from one word
	assign src_raw = (op_dtype == DT_DOUBLE) ? fpr_rdata : {32'h00000000, src_word};

	rfm_operand_unit u_operand (
		.raw(src_raw),
		.dtype(op_dtype),
		.is_signed(op_signed),
		.ext(ext_w),
		.fclass(fclass_w)
	);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			op_value <= LONG_RESET;
			op_fclass <= FC_ZERO;
		end else begin
			op_value <= ext_w;
			op_fclass <= fclass_w;
		end
	end
endmodule : rfm_register_file
`default_nettype wire

// file: pkg/rfm_pkg.sv
`default_nettype none
package rfm_pkg;
	localparam int WORD_W = 32;
	localparam int LONG_W = 64;
	localparam int GPR_IDX_W = 5;
	localparam int BANK_IDX_W = 4;
	localparam int FPR_IDX_W = 3;
	localparam int FPR_NUM = 8;
	localparam int GPR_NUM = 32;
	localparam int SYS_SEL_W = 3;
	localparam logic [WORD_W-1:0] IP_RESET = 32'h00000000;
	localparam logic [WORD_W-1:0] WORD_RESET = 32'h00000000;
	localparam logic [LONG_W-1:0] LONG_RESET = 64'h0000000000000000;
	localparam logic [GPR_IDX_W-1:0] SUP_BANK_BIT = 5'h10;
	localparam int SP_EXP_LSB = 23;
	localparam int SP_EXP_W = 8;
	localparam int SP_FRAC_W = 23;
	localparam logic [SP_EXP_W-1:0] SP_EXP_MAX = 8'hFF;
	localparam int PARCEL_W = 16;
	localparam int DIRECT_OPS = 101;
	localparam int MACRO_OPS = 67;
	localparam logic [7:0] MACRO_OPCODE_BASE = 8'hB4;
	localparam logic [2:0] LEN_ONE = 3'h1;
	localparam logic [2:0] LEN_TWO = 3'h2;
	localparam logic [2:0] LEN_THREE = 3'h3;
	localparam logic [2:0] LEN_FOUR = 3'h4;
	localparam logic [3:0] FMT_IMM16 = 4'h1;
	localparam logic [3:0] FMT_IMM32 = 4'h2;
	localparam logic [3:0] FMT_ABS32 = 4'h3;
	localparam logic [3:0] FMT_DISP_LONG = 4'h4;
	typedef enum logic [2:0] {
		SYS_SUP_BASE,
		SYS_USER_BASE,
		SYS_FAULT,
		SYS_CONTROL,
		SYS_RESET
	} rfm_sys_sel_t;
	typedef enum logic [1:0] {
		SRC_MEM,
		SRC_REG,
		SRC_IMM
	} rfm_src_t;
	typedef enum logic [2:0] {
		DT_BYTE,
		DT_HALF,
		DT_WORD,
		DT_LONG,
		DT_SINGLE,
		DT_DOUBLE
	} rfm_dtype_t;
	typedef enum logic [2:0] {
		FC_NORMAL,
		FC_ZERO,
		FC_DENORM,
		FC_INF,
		FC_QNAN,
		FC_SNAN
	} rfm_fclass_t;
endpackage : rfm_pkg
`default_nettype wire

// file: tb/rfm_exec_model.sv
`timescale 1ns/10ps
`default_nettype none
module rfm_exec_model (
	input wire logic clk_sys,
	output var logic fault_ev,
	output var logic [rfm_pkg::WORD_W-1:0] fault_vaddr
);
	initial begin
		fault_ev = 1'b0;
		fault_vaddr = 32'h0;
	end
	// address is inverted after the pulse so a stale value can never pass as a match
	task automatic fire(input logic [rfm_pkg::WORD_W-1:0] a);
		fault_ev = 1'b1;
		fault_vaddr = a;
		@(negedge clk_sys);
		fault_ev = 1'b0;
		fault_vaddr = ~a;
	endtask : fire
endmodule : rfm_exec_model
`default_nettype wire

// file: tb/rfm_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rfm_monitor (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic sup_mode,
	input wire logic [rfm_pkg::GPR_IDX_W-1:0] gpr_raddr,
	input wire logic gpr_rviol,
	input wire logic gpr_we,
	input wire logic [rfm_pkg::GPR_IDX_W-1:0] gpr_waddr,
	input wire logic gpr_wviol,
	input wire logic pstat_we,
	input wire logic [rfm_pkg::WORD_W-1:0] pstat_wdata,
	input wire logic [rfm_pkg::WORD_W-1:0] program_status_word,
	input wire logic sstat_we,
	input wire logic [rfm_pkg::WORD_W-1:0] system_status_word,
	input wire logic sstat_viol,
	input wire logic ctu_we,
	input wire logic ctu_viol,
	input wire logic fault_ev,
	input wire logic [rfm_pkg::WORD_W-1:0] fault_vaddr,
	input wire logic [rfm_pkg::WORD_W-1:0] fault_address,
	input wire logic [rfm_pkg::PARCEL_W-1:0] parcel0,
	input wire logic [2:0] insn_len
);
	import rfm_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_rviol; !sup_mode && gpr_raddr[4] |=> gpr_rviol; endproperty
	a_rviol: assert property (p_rviol) else $error("user upper read not flagged");
	property p_rclr; sup_mode |=> !gpr_rviol; endproperty
	a_rclr: assert property (p_rclr) else $error("supervisor read flagged");
	property p_wviol; gpr_we && !sup_mode && gpr_waddr[4] |=> gpr_wviol; endproperty
	a_wviol: assert property (p_wviol) else $error("user upper write not flagged");
	property p_sstat;
		sstat_we && !sup_mode |=> sstat_viol && $stable(system_status_word);
	endproperty
	a_sstat: assert property (p_sstat) else $error("user status write not refused");
	property p_pstat; pstat_we |-> ##1 program_status_word == $past(pstat_wdata); endproperty
	a_pstat: assert property (p_pstat) else $error("program status write lost");
	property p_flt; fault_ev |=> fault_address == $past(fault_vaddr); endproperty
	a_flt: assert property (p_flt) else $error("fault address not loaded");
	property p_ctu; ctu_we && !sup_mode |=> ctu_viol; endproperty
	a_ctu: assert property (p_ctu) else $error("user unit write not refused");
	property p_len; parcel0[3:0] == FMT_DISP_LONG |=> insn_len == LEN_FOUR; endproperty
	a_len: assert property (p_len) else $error("long format length wrong");
endmodule : rfm_monitor
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import rfm_pkg::*;
	typedef struct {string n; logic [63:0] v;} rfm_note_t;
	logic clk_sys = 1'b0, rstn = 1'b0, sup_mode = 1'b1, ip_we = 1'b0, gpr_we = 1'b0;
	logic fpr_we = 1'b0, pstat_we = 1'b0, sstat_we = 1'b0, ctu_we = 1'b0, op_signed = 1'b0;
	logic [31:0] ip_wdata = '0, gpr_wdata = '0, pstat_wdata = '0, sstat_wdata = '0;
	logic [31:0] ctu_wdata = '0;
	logic [31:0] op_mem = '0, op_imm = '0, x, fault_vaddr, gv[32];
	logic [4:0] gpr_raddr = '0, gpr_waddr = '0;
	logic [2:0] fpr_raddr = '0, fpr_waddr = '0, insn_len;
	logic [63:0] fpr_wdata = '0, fpr_rdata, op_value, fv[8];
	logic [15:0] parcel0 = '0;
	logic u, fault_ev, gpr_rviol, gpr_wviol, sstat_viol, ctu_viol, insn_macro;
	logic [31:0] ip_q, gpr_rdata, program_status_word, system_status_word, ctu_rdata;
	logic [31:0] supervisor_directory_base, user_directory_base, ctu_control;
	logic [31:0] ctu_reset_reg, fault_address;
	rfm_sys_sel_t ctu_sel = SYS_SUP_BASE;
	rfm_src_t op_src = SRC_IMM;
	rfm_dtype_t op_dtype = DT_WORD;
	rfm_fclass_t op_fclass;
	rfm_note_t q[$];
	rfm_note_t nt;
	int bad_count = 0, checks = 0, seed = 32'h9b0d;
	logic [31:0] fp_v[7] = '{32'h7F800000, 32'h7FC00000, 32'h7F800001, 32'h0, 32'h3F800000,
		32'h1, 32'hFFBFFFFF};
	rfm_fclass_t fp_c[7] = '{FC_INF, FC_QNAN, FC_SNAN, FC_ZERO, FC_NORMAL, FC_DENORM, FC_SNAN};
	logic [15:0] parc[9] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'hB400, 16'hF604,
		16'hB301, 16'hF700};
	logic [3:0] pl[9] = '{4'h1, 4'h2, 4'h3, 4'h3, 4'h4, 4'h9, 4'hC, 4'h2, 4'h1};
	logic pm[3] = '{1'b1, 1'b0, 1'b1};
	rfm_register_file dut_u (.*);
	rfm_exec_model em_u (.clk_sys, .fault_ev, .fault_vaddr);
	initial forever #50 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [63:0] s, logic [63:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic note(string n, logic [63:0] v);
		q.push_back('{n, v});
	endtask : note
	task automatic cyc();
		@(negedge clk_sys);
	endtask : cyc
	function automatic logic [63:0] ext(logic [31:0] v, int w, logic s);
		logic [63:0] m;
		m = (64'h1 << w) - 64'h1;
		return ({32'h0, v} & m) | ((s && v[w-1]) ? ~m : 64'h0);
	endfunction : ext
	task automatic results();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////////////
	// results land at the posedge after the negedge that set them; sample 1 ns later
	always @(posedge clk_sys) begin
		#1;
		while (q.size() > 0) begin
			nt = q.pop_front();
			case (nt.n)
				"gpr": chk(nt.n, {gpr_rviol, gpr_rdata}, nt.v);
				"wv": chk(nt.n, gpr_wviol, nt.v);
				"fpr": chk(nt.n, fpr_rdata, nt.v);
				"ip": chk(nt.n, ip_q, nt.v);
				"pst": chk(nt.n, program_status_word, nt.v);
				"sst": chk(nt.n, {sstat_viol, system_status_word}, nt.v);
				"cr": chk(nt.n, {ctu_control, ctu_reset_reg}, nt.v);
				"ctu": chk(nt.n, {ctu_viol, ctu_rdata}, nt.v);
				"dir": chk(nt.n, {supervisor_directory_base, user_directory_base}, nt.v);
				"flt": chk(nt.n, fault_address, nt.v);
				"op": chk(nt.n, op_value, nt.v);
				"fc": chk(nt.n, op_fclass, nt.v);
				"len": chk(nt.n, {insn_macro, insn_len}, nt.v);
			endcase
		end
	end
	initial begin
		#100000;
		bad_count++;
		results();
	end
	initial begin
		repeat (7) cyc();
		note("pst", 0);
		note("sst", 0);
		note("ip", 0);
		note("flt", 0);
		note("len", 1);
		cyc();
		rstn = 1'b1;
		for (int i = 0; i < 32; i++) begin
			gv[i] = $random(seed);
			if (i < 8) fv[i] = {$random(seed), gv[i]};
			{gpr_we, gpr_waddr, gpr_wdata} = {1'b1, i[4:0], gv[i]};
			{fpr_we, fpr_waddr, fpr_wdata} = {1'b1, i[2:0], fv[i[2:0]]};
			cyc();
		end
		{gpr_we, fpr_we} = 2'h0;
		// middle pass is user mode: upper reads refused, writes cross-wired to the other bank
		foreach (pm[p]) begin
			sup_mode = pm[p];
			for (int i = 0; i < 32; i++) begin
				{gpr_raddr, fpr_raddr} = {i[4:0], i[2:0]};
				u = !sup_mode && i > 15;
				note("gpr", {u, u ? 32'h0 : gv[i]});
				note("fpr", fv[i[2:0]]);
				if (p == 1) begin
					{gpr_we, gpr_waddr, gpr_wdata} = {1'b1, i[4:0] ^ 5'h10, ~gv[i]};
					note("wv", i < 16);
					if (i > 15) gv[i-16] = ~gv[i];
				end
				cyc();
			end
			if (p == 1) gpr_we = 1'b0;
		end
		sup_mode = 1'b0;
		{ip_we, ip_wdata, pstat_we, pstat_wdata} = {1'b1, gv[3], 1'b1, gv[1]};
		{sstat_we, sstat_wdata, ctu_we, ctu_wdata} = {1'b1, gv[2], 1'b1, gv[6]};
		ctu_sel = SYS_CONTROL;
		note("ip", gv[3]);
		note("pst", gv[1]);
		note("sst", 33'h100000000);
		note("ctu", 33'h100000000);
		note("cr", 64'h0);
		cyc();
		{sup_mode, ip_we, pstat_we} = 3'h4;
		for (int s = 0; s < 5; s++) begin
			ctu_sel = rfm_sys_sel_t'(s);
			{sstat_wdata, ctu_wdata} = {gv[s], gv[s+8]};
			note("sst", gv[s]);
			cyc();
		end
		{sstat_we, ctu_we} = 2'h0;
		note("dir", {gv[8], gv[9]});
		note("cr", {gv[11], gv[12]});
		for (int s = 0; s < 5; s++) begin
			ctu_sel = rfm_sys_sel_t'(s);
			note("ctu", gv[s+8]);
			cyc();
		end
		{ctu_we, ctu_wdata} = {1'b1, gv[0]};
		ctu_sel = SYS_FAULT;
		note("flt", gv[4]);
		em_u.fire(gv[4]);
		ctu_we = 1'b0;
		note("ctu", gv[4]);
		cyc();
		sup_mode = 1'b0;
		note("ctu", 0);
		cyc();
		sup_mode = 1'b1;
		for (int k = 0; k < 12; k++) begin
			x = k[0] ? (gv[5] | 32'h80008080) : (gv[5] & 32'h7FFF7F7F);
			// the unselected source carries the inverse so a wrong pick shows
			{op_imm, op_mem, op_signed} = k[0] ? {~x, x, k[1]} : {x, ~x, k[1]};
			op_src = k[0] ? SRC_MEM : SRC_IMM;
			op_dtype = rfm_dtype_t'(k / 4);
			note("op", ext(x, 8 << (k / 4), k[1]));
			cyc();
		end
		{gpr_raddr, fpr_raddr} = {5'h7, 3'h5};
		cyc();
		op_src = SRC_REG;
		op_dtype = DT_WORD;
		op_signed = 1'b0;
		note("op", {32'h0, gv[7]});
		cyc();
		op_dtype = DT_DOUBLE;
		note("op", fv[5]);
		cyc();
		op_src = SRC_IMM;
		op_dtype = DT_LONG;
		note("op", {32'h0, op_imm});
		cyc();
		op_dtype = DT_SINGLE;
		for (int i = 0; i < 9; i++) begin
			parcel0 = parc[i];
			note("len", pl[i]);
			if (i < 7) begin
				op_imm = fp_v[i];
				note("fc", fp_c[i]);
				note("op", {32'h0, fp_v[i]});
			end
			cyc();
		end
		cyc();
		results();
	end
endmodule : tb_top
bind rfm_register_file rfm_monitor mon_u (.*);
`default_nettype wire
